// ---- logic/auto_reload_timer.sv ----
// sixteen-bit auto-reload up-counter with prescaler, AXI4-Lite registers
// assumes one clock; isr_enter comes from the CPU core on the same clock
//
// Behaviour
// - one sixteen-bit counter, up only, auto-reload
// - select divides by one up to 128
// - counter halts when run is zero
// - rollover sets flag, loads reload value
// - flag and enable request the timer interrupt
// - entering service routine clears the flag
// - reload held in low and high bytes
// - overflow offered as serial baud source
`timescale 1ns/1ps
`default_nettype none

module auto_reload_timer
   import timer3_pkg::*;
#(
   parameter int ADDR_W = 12
) (
   // clock and reset
   input  wire logic              clock,
   input  wire logic              sys_rst,
   // write address channel
   input  wire logic [ADDR_W-1:0] s_axi_awaddr,
   input  wire logic              s_axi_awvalid,
   output logic                   s_axi_awready,
   // write data channel
   input  wire logic [31:0]       s_axi_wdata,
   input  wire logic [3:0]        s_axi_wstrb,
   input  wire logic              s_axi_wvalid,
   output logic                   s_axi_wready,
   // write response channel
   output logic [1:0]             s_axi_bresp,
   output logic                   s_axi_bvalid,
   input  wire logic              s_axi_bready,
   // read address channel
   input  wire logic [ADDR_W-1:0] s_axi_araddr,
   input  wire logic              s_axi_arvalid,
   output logic                   s_axi_arready,
   // read data channel
   output logic [31:0]            s_axi_rdata,
   output logic [1:0]             s_axi_rresp,
   output logic                   s_axi_rvalid,
   input  wire logic              s_axi_rready,
   // cpu interrupt link
   input  wire logic              isr_enter,
   output logic                   timer3_irq_request,
   // system interrupt
   output logic                   irq,
   // serial port baud source
   output logic                   baud_tick
);

   // -----------------------------------------
   // state and prescaler
   // -----------------------------------------
   ctrl_t             ctrl_reg;       // timer3_control fields
   ctrl_t             ctrl_next;
   logic [7:0]        rl_low_reg;     // timer3_reload_low
   logic [7:0]        rl_high_reg;    // timer3_reload_high
   logic [CNT_W-1:0]  cnt_reg;        // the counter itself
   logic [CNT_W-1:0]  cnt_next;
   logic              ie_reg;         // timer3_interrupt_enable
   logic              stat_reg;       // sticky overflow event
   logic              stat_next;
   logic              mask_reg;       // event mask
   logic              baud_reg;       // registered baud pulse
   // bus slave state
   logic              aw_have_reg;    // write address held
   logic [ADDR_W-1:0] aw_addr_reg;    // held write address
   logic              w_have_reg;     // write data held
   logic [31:0]       w_data_reg;     // held write data
   logic [3:0]        w_strb_reg;     // held byte enables
   logic              bvalid_reg;     // write answer pending
   logic [1:0]        bresp_reg;      // write answer code
   logic              rvalid_reg;     // read answer pending
   logic [31:0]       rdata_reg;      // read answer data
   logic [1:0]        rresp_reg;      // read answer code

   // prescaler, restarted whenever run rises
   logic pre_tick;  // one-cycle enable for the counter
   timer_prescaler #(.W (PRE_W)) u_prescaler (
      .clock   (clock),
      .sys_rst (sys_rst),
      .enable  (ctrl_reg.run),
      .select  (ctrl_reg.ps),
      .tick    (pre_tick)
   );

   // -----------------------------------------
   // write path decode
   // -----------------------------------------
   logic wr_fire;       // both halves held, perform write
   logic wr_lane0;      // low byte enabled
   logic wr_ctrl;       // write to control
   logic wr_rl_low;     // write to reload low
   logic wr_rl_high;    // write to reload high
   logic wr_stat;       // write to status
   logic wr_mask;       // write to mask
   logic wr_ie;         // write to interrupt enable
   logic wr_hit;        // address is mapped
   logic aw_fire;       // write address taken
   logic w_fire;        // write data taken

   // channels take their halves independently; both stall while answer waits
   assign s_axi_awready = !aw_have_reg && !bvalid_reg;
   assign s_axi_wready  = !w_have_reg && !bvalid_reg;
   assign aw_fire       = s_axi_awvalid && s_axi_awready;
   assign w_fire        = s_axi_wvalid && s_axi_wready;
   assign wr_fire       = aw_have_reg && w_have_reg;
   assign wr_lane0      = w_strb_reg[0];

   // all writable registers are one byte or less, so only lane zero writes
   assign wr_ctrl    = wr_fire && wr_lane0 && (aw_addr_reg == ADDR_CONTROL);
   assign wr_rl_low  = wr_fire && wr_lane0 && (aw_addr_reg == ADDR_RELOAD_LOW);
   assign wr_rl_high = wr_fire && wr_lane0 && (aw_addr_reg == ADDR_RELOAD_HIGH);
   assign wr_stat    = wr_fire && wr_lane0 && (aw_addr_reg == ADDR_IRQ_STATUS);
   assign wr_mask    = wr_fire && wr_lane0 && (aw_addr_reg == ADDR_IRQ_MASK);
   assign wr_ie      = wr_fire && wr_lane0 && (aw_addr_reg == ADDR_INT_ENABLE);
   assign wr_hit     = (aw_addr_reg == ADDR_CONTROL) || (aw_addr_reg == ADDR_RELOAD_LOW)
                    || (aw_addr_reg == ADDR_RELOAD_HIGH) || (aw_addr_reg == ADDR_IRQ_STATUS)
                    || (aw_addr_reg == ADDR_IRQ_MASK) || (aw_addr_reg == ADDR_INT_ENABLE)
                    || (aw_addr_reg == ADDR_COUNT);

   // -----------------------------------------
   // counter, control and reload
   // -----------------------------------------
   logic             ovf_evt;     // rollover this cycle
   logic [CNT_W-1:0] reload_val;  // sixteen-bit reload image

   assign reload_val = {rl_high_reg, rl_low_reg};
   assign ovf_evt    = pre_tick && (cnt_reg == COUNT_TOP);
   // step only on a prescaler tick; tick is never high while halted
   assign cnt_next   = !pre_tick ? cnt_reg
                     : ovf_evt   ? reload_val
                     : CNT_W'(cnt_reg + 1'b1);

   // counter register, no software write path
   always_ff @(posedge clock) begin
      if (sys_rst) begin
         cnt_reg <= COUNT_RESET;
      end else begin
         cnt_reg <= cnt_next;
      end
   end

   // rollover beats service entry, which beats a software write,
   // so an overflow in the clearing cycle is never lost
   always_comb begin
      ctrl_next = ctrl_reg;
      if (wr_ctrl) begin
         ctrl_next.run = w_data_reg[CTRL_RUN_BIT];
         ctrl_next.ps  = w_data_reg[CTRL_PS_LSB +: PS_W];
         ctrl_next.flag = w_data_reg[CTRL_FLAG_BIT];
      end
      if (isr_enter) begin
         ctrl_next.flag = 1'b0;
      end
      if (ovf_evt) begin
         ctrl_next.flag = 1'b1;
      end
   end

   // control and enable registers
   always_ff @(posedge clock) begin
      if (sys_rst) begin
         ctrl_reg <= CTRL_RESET;
         ie_reg   <= 1'b0;
      end else begin
         ctrl_reg <= ctrl_next;
         if (wr_ie) begin
            ie_reg <= w_data_reg[0];
         end
      end
   end

   // no guard against writes while running; software must halt first
   always_ff @(posedge clock) begin
      if (sys_rst) begin
         rl_low_reg  <= RELOAD_RESET;
         rl_high_reg <= RELOAD_RESET;
      end else begin
         if (wr_rl_low) begin
            rl_low_reg <= w_data_reg[7:0];
         end
         if (wr_rl_high) begin
            rl_high_reg <= w_data_reg[7:0];
         end
      end
   end

   // -----------------------------------------
   // interrupts and baud source
   // -----------------------------------------
   // write one clears; a same-cycle event keeps the bit set
   assign stat_next = (stat_reg && !(wr_stat && w_data_reg[STAT_OVF_BIT])) || ovf_evt;
   assign irq                = stat_reg && mask_reg;
   assign timer3_irq_request = ctrl_reg.flag && ie_reg;
   assign baud_tick          = baud_reg;

   // status, mask and baud pulse
   always_ff @(posedge clock) begin
      if (sys_rst) begin
         stat_reg <= 1'b0;
         mask_reg <= 1'b0;
         baud_reg <= 1'b0;
      end else begin
         stat_reg <= stat_next;
         baud_reg <= ovf_evt;
         if (wr_mask) begin
            mask_reg <= w_data_reg[STAT_OVF_BIT];
         end
      end
   end

   // -----------------------------------------
   // write answer and read path
   // -----------------------------------------
   always_ff @(posedge clock) begin
      if (sys_rst) begin
         aw_have_reg <= 1'b0;
         aw_addr_reg <= '0;
         w_have_reg  <= 1'b0;
         w_data_reg  <= '0;
         w_strb_reg  <= '0;
         bvalid_reg  <= 1'b0;
         bresp_reg   <= RESP_OKAY;
      end else begin
         // hold address until the pair completes
         if (aw_fire) begin
            aw_have_reg <= 1'b1;
            aw_addr_reg <= s_axi_awaddr;
         end
         // hold data until the pair completes
         if (w_fire) begin
            w_have_reg <= 1'b1;
            w_data_reg <= s_axi_wdata;
            w_strb_reg <= s_axi_wstrb;
         end
         // pair done: answer, unmapped gets an error
         if (wr_fire) begin
            aw_have_reg <= 1'b0;
            w_have_reg  <= 1'b0;
            bvalid_reg  <= 1'b1;
            bresp_reg   <= wr_hit ? RESP_OKAY : RESP_SLVERR;
         end else if (bvalid_reg && s_axi_bready) begin
            bvalid_reg <= 1'b0;
         end
      end
   end

   assign s_axi_bvalid = bvalid_reg;
   assign s_axi_bresp  = bresp_reg;

   logic [31:0] rd_word;  // decoded read value
   logic        rd_hit;   // address is mapped
   logic        ar_fire;  // read address taken

   assign s_axi_arready = !rvalid_reg;
   assign ar_fire       = s_axi_arvalid && s_axi_arready;
   assign rd_hit = (s_axi_araddr == ADDR_CONTROL) || (s_axi_araddr == ADDR_RELOAD_LOW)
                || (s_axi_araddr == ADDR_RELOAD_HIGH) || (s_axi_araddr == ADDR_IRQ_STATUS)
                || (s_axi_araddr == ADDR_IRQ_MASK) || (s_axi_araddr == ADDR_INT_ENABLE)
                || (s_axi_araddr == ADDR_COUNT);
   // serial-port bits of control are not held here and read zero
   assign rd_word =
        (s_axi_araddr == ADDR_CONTROL)     ? {27'h0, ctrl_reg}
      : (s_axi_araddr == ADDR_RELOAD_LOW)  ? {24'h0, rl_low_reg}
      : (s_axi_araddr == ADDR_RELOAD_HIGH) ? {24'h0, rl_high_reg}
      : (s_axi_araddr == ADDR_IRQ_STATUS)  ? {31'h0, stat_reg}
      : (s_axi_araddr == ADDR_IRQ_MASK)    ? {31'h0, mask_reg}
      : (s_axi_araddr == ADDR_INT_ENABLE)  ? {31'h0, ie_reg}
      : (s_axi_araddr == ADDR_COUNT)       ? {16'h0, cnt_reg}
      : 32'h0000_0000;

   // read answer registers
   always_ff @(posedge clock) begin
      if (sys_rst) begin
         rvalid_reg <= 1'b0;
         rdata_reg  <= '0;
         rresp_reg  <= RESP_OKAY;
      end else begin
         if (ar_fire) begin
            rvalid_reg <= 1'b1;
            rdata_reg  <= rd_word;
            rresp_reg  <= rd_hit ? RESP_OKAY : RESP_SLVERR;
         end else if (rvalid_reg && s_axi_rready) begin
            rvalid_reg <= 1'b0;
         end
      end
   end

   assign s_axi_rvalid = rvalid_reg;
   assign s_axi_rdata  = rdata_reg;
   assign s_axi_rresp  = rresp_reg;

   // -----------------------------------------
   // assertions
   // -----------------------------------------
   default clocking cb @(posedge clock); endclocking
   default disable iff (sys_rst);

   // counting step is exactly one up
   property p_count_up;
      pre_tick && (cnt_reg != COUNT_TOP) |=> cnt_reg == $past(cnt_reg) + 16'h0001;
   endproperty
   a_count_up: assert property (p_count_up) else $error("count did not step by one");
   // divide by two never ticks twice in a row
   property p_div2;
      ctrl_reg.run && ctrl_reg.ps == 3'h1 && pre_tick ##1
      ctrl_reg.run && ctrl_reg.ps == 3'h1 |-> !pre_tick;
   endproperty
   a_div2: assert property (p_div2) else $error("divide by two ticked twice");
   // halted counter holds
   property p_halt;
      !ctrl_reg.run |=> $stable(cnt_reg);
   endproperty
   a_halt: assert property (p_halt) else $error("count moved while halted");
   // rollover reloads and raises the flag
   property p_reload;
      ovf_evt |=> (cnt_reg == $past(reload_val)) && ctrl_reg.flag;
   endproperty
   a_reload: assert property (p_reload) else $error("rollover without reload");
   // enabled rollover requests service in the next cycle
   property p_irq_req;
      ovf_evt && ie_reg && !wr_ie |=> timer3_irq_request;
   endproperty
   a_irq_req: assert property (p_irq_req) else $error("no service request");
   // service entry clears the flag
   property p_isr_clear;
      isr_enter && !ovf_evt |=> !ctrl_reg.flag;
   endproperty
   a_isr_clear: assert property (p_isr_clear) else $error("flag kept on service entry");
   // software may set the flag
   property p_sw_set;
      wr_ctrl && w_data_reg[CTRL_FLAG_BIT] && !isr_enter |=> ctrl_reg.flag;
   endproperty
   a_sw_set: assert property (p_sw_set) else $error("software set lost");
   // low reload byte takes written data
   property p_rl_low;
      wr_rl_low |=> rl_low_reg == $past(w_data_reg[7:0]);
   endproperty
   a_rl_low: assert property (p_rl_low) else $error("reload low not written");
   // baud pulse one cycle after rollover
   property p_baud;
      ovf_evt |=> baud_tick ##1 (baud_tick == $past(ovf_evt));
   endproperty
   a_baud: assert property (p_baud) else $error("baud pulse missing");
   // divide by one steps every cycle
   property p_div1;
      ctrl_reg.run && ctrl_reg.ps == 3'h0 |-> pre_tick;
   endproperty
   a_div1: assert property (p_div1) else $error("divide by one missed a cycle");

   // main scenarios
   c_overflow: cover property (ovf_evt);
   c_irq: cover property (irq);
   c_isr_race: cover property (isr_enter && ovf_evt);
   c_div128: cover property (ctrl_reg.ps == 3'h7 && ovf_evt);

endmodule

`default_nettype wire

// ---- logic/timer3_pkg.sv ----
// constants and carrier types for the auto-reload timer
// assumes a 32-bit AXI4-Lite register bus and one synchronous clock domain
package timer3_pkg;

   // -----------------------------------------
   // register indices
   // -----------------------------------------
   localparam logic [7:0] IDX_CONTROL     = 8'hC4;  // timer3_control
   localparam logic [7:0] IDX_RELOAD_LOW  = 8'hC5;  // timer3_reload_low
   localparam logic [7:0] IDX_RELOAD_HIGH = 8'hC6;  // timer3_reload_high

   // -----------------------------------------
   // byte addresses on the bus
   // -----------------------------------------
   localparam logic [11:0] ADDR_CONTROL     = {2'h0, IDX_CONTROL, 2'h0};
   localparam logic [11:0] ADDR_RELOAD_LOW  = {2'h0, IDX_RELOAD_LOW, 2'h0};
   localparam logic [11:0] ADDR_RELOAD_HIGH = {2'h0, IDX_RELOAD_HIGH, 2'h0};
   localparam logic [11:0] ADDR_IRQ_STATUS  = 12'h320;  // sticky events, w1c
   localparam logic [11:0] ADDR_IRQ_MASK    = 12'h324;  // event mask
   localparam logic [11:0] ADDR_INT_ENABLE  = 12'h328;  // timer3_interrupt_enable
   localparam logic [11:0] ADDR_COUNT       = 12'h32C;  // live counter, read only

   // -----------------------------------------
   // field positions
   // -----------------------------------------
   localparam int CTRL_FLAG_BIT = 4;  // timer3_overflow_flag
   localparam int CTRL_RUN_BIT  = 3;  // timer3_run
   localparam int CTRL_PS_LSB   = 0;  // timer3_prescale_select
   localparam int PS_W          = 3;  // prescale select width
   localparam int PRE_W         = 7;  // prescaler counter width, up to 1/128
   localparam int CNT_W         = 16; // timer width
   localparam int STAT_OVF_BIT  = 0;  // overflow event in status and mask

   // -----------------------------------------
   // reset values and limits
   // -----------------------------------------
   localparam logic [7:0]       RELOAD_RESET = 8'h00;
   localparam logic [CNT_W-1:0] COUNT_RESET  = 16'h0000;
   localparam logic [CNT_W-1:0] COUNT_TOP    = 16'hFFFF;
   localparam logic [1:0]       RESP_OKAY    = 2'h0;
   localparam logic [1:0]       RESP_SLVERR  = 2'h2;

   // -----------------------------------------
   // carrier types
   // -----------------------------------------
   typedef struct packed {
      logic            flag;  // overflow flag
      logic            run;   // run control
      logic [PS_W-1:0] ps;    // prescale select
   } ctrl_t;

   localparam ctrl_t CTRL_RESET = '{flag: 1'b0, run: 1'b0, ps: 3'h0};

endpackage

// ---- logic/timer_prescaler.sv ----
// power-of-two clock-enable divider for the timer
// assumes select is held from a register in the same clock domain
`timescale 1ns/1ps
`default_nettype none

module timer_prescaler
   import timer3_pkg::*;
#(
   parameter int W = PRE_W
) (
   // clock and reset
   input  wire logic            clock,
   input  wire logic            sys_rst,
   // control
   input  wire logic            enable,
   input  wire logic [PS_W-1:0] select,
   // output
   output logic                 tick
);

   // -----------------------------------------
   // divider
   // -----------------------------------------
   logic [W-1:0] div_reg;   // free count while enabled
   logic [W-1:0] div_next;  // next count
   logic [W-1:0] div_mask;  // low bits that must be all ones

   // mask of 2^select - 1; select 0 gives an empty mask, a tick each cycle
   assign div_mask = W'((1 << select) - 1);
   assign tick     = enable && ((div_reg & div_mask) == div_mask);
   // halted divider restarts from zero so the first period is whole
   assign div_next = enable ? W'(div_reg + 1'b1) : '0;

   // divider register
   always_ff @(posedge clock) begin
      if (sys_rst) begin
         div_reg <= '0;
      end else begin
         div_reg <= div_next;
      end
   end

endmodule

`default_nettype wire

// ---- tb/testbench.sv ----
// self-checking bench for the auto-reload timer, driven over AXI4-Lite
// assumes the design package and the timer with its prescaler are compiled first
`timescale 1ns/1ps
`default_nettype none

module testbench
   import timer3_pkg::*;
;
   // ---------------------------------
   // signals and bench state
   // ---------------------------------
   logic        clock;          // 100 MHz system clock
   logic        sys_rst;        // synchronous reset
   logic [11:0] s_axi_awaddr;
   logic        s_axi_awvalid, s_axi_awready;
   logic [31:0] s_axi_wdata;
   logic [3:0]  s_axi_wstrb;
   logic        s_axi_wvalid, s_axi_wready;
   logic [1:0]  s_axi_bresp;
   logic        s_axi_bvalid, s_axi_bready;
   logic [11:0] s_axi_araddr;
   logic        s_axi_arvalid, s_axi_arready;
   logic [31:0] s_axi_rdata;
   logic [1:0]  s_axi_rresp;
   logic        s_axi_rvalid, s_axi_rready;
   logic        isr_enter, timer3_irq_request, irq, baud_tick;
   logic [31:0] rd_data;        // last read word
   logic [1:0]  rd_resp, wr_resp; // last responses
   logic [31:0] first_count;    // count seen while halted
   logic [7:0]  lo;             // random reload low byte
   int          errors, check_count, cycles, n, seed;
   localparam int LIMIT = 90000; // first rollover alone takes 65536 cycles

   // ---------------------------------
   // design under test
   // ---------------------------------
   auto_reload_timer u_auto_reload_timer (
      .clock(clock), .sys_rst(sys_rst),
      .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
      .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
      .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
      .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
      .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
      .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
      .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
      .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
      .s_axi_rready(s_axi_rready), .isr_enter(isr_enter),
      .timer3_irq_request(timer3_irq_request), .irq(irq), .baud_tick(baud_tick)
   );

   // free-running clock, 10 ns period
   initial begin
      clock = 1'b0;
      forever #5 clock = ~clock;
   end

   // hang guard: a run past the ceiling counts as a mismatch
   always @(posedge clock) begin
      cycles <= cycles + 1;
      if (cycles == LIMIT) begin
         errors = errors + 1;
         report_and_stop();
      end
   end

   // ---------------------------------
   // checking and closing
   // ---------------------------------
   task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
      check_count = check_count + 1;
      if (seen !== exp) begin
         errors = errors + 1;
         $display("wrong value %s expected %h seen %h", name, exp, seen);
      end
   endtask

   task automatic report_and_stop();
      $display("checks %0d mismatches %0d", check_count, errors);
      if (errors == 0 && check_count > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask

   // ---------------------------------
   // bus master tasks
   // ---------------------------------
   // handshakes sampled at the falling edge: inputs only move after a rising
   // edge, so this equals what the next rising edge sees, without a race
   task automatic axi_write(input logic [11:0] a, input logic [31:0] d, input logic [3:0] s);
      logic ah, wh, bh;
      @(posedge clock);
      s_axi_awaddr  <= a;
      s_axi_awvalid <= 1'b1;
      s_axi_wdata   <= d;
      s_axi_wstrb   <= s;
      s_axi_wvalid  <= 1'b1;
      s_axi_bready  <= 1'b1;
      bh = 1'b0;
      while (!bh) begin
         @(negedge clock);
         ah = s_axi_awvalid && s_axi_awready;
         wh = s_axi_wvalid && s_axi_wready;
         bh = (s_axi_bvalid === 1'b1);
         wr_resp = s_axi_bresp;
         @(posedge clock);
         if (ah) s_axi_awvalid <= 1'b0;
         if (wh) s_axi_wvalid <= 1'b0;
         if (bh) s_axi_bready <= 1'b0;
      end
   endtask

   task automatic axi_read(input logic [11:0] a);
      logic ah, rh;
      @(posedge clock);
      s_axi_araddr  <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready  <= 1'b1;
      rh = 1'b0;
      while (!rh) begin
         @(negedge clock);
         ah = s_axi_arvalid && s_axi_arready;
         rh = (s_axi_rvalid === 1'b1);
         rd_data = s_axi_rdata;
         rd_resp = s_axi_rresp;
         @(posedge clock);
         if (ah) s_axi_arvalid <= 1'b0;
         if (rh) s_axi_rready <= 1'b0;
      end
   endtask

   // read one word and compare data and response
   task automatic rd_check(input logic [11:0] a, input logic [31:0] exp, input logic [1:0] r);
      axi_read(a);
      check("read data", rd_data, exp);
      check("read resp", 32'(rd_resp), 32'(r));
   endtask

   // cycles up to and including the next overflow pulse
   task automatic wait_tick(output int k);
      k = 0;
      do begin
         @(negedge clock);
         k = k + 1;
      end while (baud_tick !== 1'b1);
   endtask

   // one-cycle service-entry pulse from the cpu side
   task automatic pulse_isr();
      @(posedge clock);
      isr_enter <= 1'b1;
      @(posedge clock);
      isr_enter <= 1'b0;
   endtask

   // expected overflow period for a reload of FF:lo and a select value
   function automatic logic [31:0] period(input logic [7:0] l, input int p);
      return (32'h100 - 32'(l)) << p;
   endfunction

   // ---------------------------------
   // main sequence
   // ---------------------------------
   initial begin
      {s_axi_awaddr, s_axi_awvalid, s_axi_wdata, s_axi_wstrb, s_axi_wvalid} = '0;
      {s_axi_bready, s_axi_araddr, s_axi_arvalid, s_axi_rready, isr_enter} = '0;
      errors = 0;
      check_count = 0;
      cycles = 0;
      seed = 70615;
      sys_rst = 1'b1;
      repeat (16) @(posedge clock);
      sys_rst <= 1'b0;
      // every register starts at zero
      rd_check(ADDR_CONTROL, 32'h0, RESP_OKAY);
      rd_check(ADDR_RELOAD_LOW, 32'(RELOAD_RESET), RESP_OKAY);
      rd_check(ADDR_RELOAD_HIGH, 32'h0, RESP_OKAY);
      rd_check(ADDR_IRQ_STATUS, 32'h0, RESP_OKAY);
      rd_check(ADDR_IRQ_MASK, 32'h0, RESP_OKAY);
      rd_check(ADDR_INT_ENABLE, 32'h0, RESP_OKAY);
      rd_check(ADDR_COUNT, 32'(COUNT_RESET), RESP_OKAY);
      check("irq request", 32'(timer3_irq_request), 32'h0);
      // unmapped and unaligned places refuse
      rd_check(12'h330, 32'h0, RESP_SLVERR);
      rd_check(12'h311, 32'h0, RESP_SLVERR);
      axi_write(12'h330, 32'hFFFF_FFFF, 4'hF);
      check("write resp", 32'(wr_resp), 32'(RESP_SLVERR));
      // control keeps five bits, upper ones read zero
      axi_write(ADDR_CONTROL, 32'hE7, 4'h1);
      rd_check(ADDR_CONTROL, 32'h07, RESP_OKAY);
      // reload bytes keep only bits 7:0; a dropped strobe changes nothing
      axi_write(ADDR_RELOAD_HIGH, {24'($random(seed)), 8'hA5}, 4'h1);
      rd_check(ADDR_RELOAD_HIGH, 32'hA5, RESP_OKAY);
      axi_write(ADDR_RELOAD_HIGH, 32'h5A, 4'h0);
      rd_check(ADDR_RELOAD_HIGH, 32'hA5, RESP_OKAY);
      // the counter cannot be written by software
      axi_write(ADDR_COUNT, 32'h1234, 4'h3);
      rd_check(ADDR_COUNT, 32'h0, RESP_OKAY);
      axi_write(ADDR_IRQ_MASK, 32'h1, 4'h1);
      axi_write(ADDR_INT_ENABLE, 32'h1, 4'h1);
      // overflow period for every select value, random reload near the top
      for (int ps = 0; ps < 8; ps++) begin
         lo = 8'hFC | 8'($random(seed) & 3);
         axi_write(ADDR_RELOAD_LOW, {24'($random(seed)), lo}, 4'h1);
         axi_write(ADDR_RELOAD_HIGH, 32'hFF, 4'h1);
         axi_write(ADDR_CONTROL, 32'h08 | 32'(ps), 4'h1);
         wait_tick(n);
         check("irq request", 32'(timer3_irq_request), 32'h1);
         check("irq", 32'(irq), 32'h1);
         wait_tick(n);
         check("overflow period", 32'(n), period(lo, ps));
         axi_write(ADDR_CONTROL, 32'(ps), 4'h1);
      end
      // halted counter holds its value
      axi_read(ADDR_COUNT);
      first_count = rd_data;
      repeat (40) @(posedge clock);
      rd_check(ADDR_COUNT, first_count, RESP_OKAY);
      // software clears, then sets the flag
      check("irq request", 32'(timer3_irq_request), 32'h0);
      axi_write(ADDR_CONTROL, 32'h10, 4'h1);
      check("irq request", 32'(timer3_irq_request), 32'h1);
      rd_check(ADDR_CONTROL, 32'h10, RESP_OKAY);
      // entering the service routine drops the flag
      pulse_isr();
      @(negedge clock);
      check("irq request", 32'(timer3_irq_request), 32'h0);
      rd_check(ADDR_CONTROL, 32'h00, RESP_OKAY);
      // enable gates the request
      axi_write(ADDR_CONTROL, 32'h10, 4'h1);
      axi_write(ADDR_INT_ENABLE, 32'h0, 4'h1);
      check("irq request", 32'(timer3_irq_request), 32'h0);
      // sticky status, masked, then cleared by writing one
      rd_check(ADDR_IRQ_STATUS, 32'h1, RESP_OKAY);
      axi_write(ADDR_IRQ_MASK, 32'h0, 4'h1);
      check("irq", 32'(irq), 32'h0);
      axi_write(ADDR_IRQ_MASK, 32'h1, 4'h1);
      check("irq", 32'(irq), 32'h1);
      axi_write(ADDR_IRQ_STATUS, 32'h1, 4'h1);
      check("irq", 32'(irq), 32'h0);
      rd_check(ADDR_IRQ_STATUS, 32'h0, RESP_OKAY);
      report_and_stop();
   end

endmodule

`default_nettype wire
